// ===== sdw_slave.sv
// two-wire write-only slave that loads a ten-bit dac code
// What this block does
// [RL1] receive-only slave, never drives read data
// [RL2] master opens with start, address, write bit
// [RL3] acknowledge matching address and command byte
// [RL4] stage command bits at command ack fall
// [RL5] load ten-bit code at data ack fall
// [RL6] code update never waits for stop
// [RL7] upper five address bits fixed, two strapped
// [RL8] four strap-selected addresses
// [RL9] both straps high: mid-scale power-up code
// [RL10] shutdown by pin low or command bit 7
// [RL11] shutdown keeps stored code unchanged
// [RL12] idle bus lines released high
// [RL13] ignore foreign address until next start
// [RL14] code msbs from command bits 1:0
`timescale 1ns/1ps
`default_nettype none

module sdw_slave (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // two-wire bus, sda open drain
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // strap and control pins
  input  wire logic       addr_strap_hi,
  input  wire logic       addr_strap_lo,
  input  wire logic       power_down_pin_n,
  // dac side
  output logic [9:0]      dac_code,
  output logic            dac_shutdown,
  output logic            code_loaded
);

  // ----------------------------------------------------------------
  // constant checks
  // ----------------------------------------------------------------
  // code register is two staged bits plus one data byte
  if (sdw_pkg::CODE_W != $bits(dac_code)) begin : g_bad_code_w
    $error("dac code width does not match the package");
  end
  // one flop cannot settle an asynchronous pin
  if (sdw_pkg::SYNC_STAGES < 2) begin : g_bad_sync
    $error("pin synchronisers need at least two stages");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sdw_pkg::sdw_pins_s pins_raw;
  sdw_pkg::sdw_pins_s pins;

  assign pins_raw = '{scl:      scl_i,
                      sda:      sda_i,
                      strap_hi: addr_strap_hi,
                      strap_lo: addr_strap_lo,
                      pd_n:     power_down_pin_n};

  sdw_sync #(
    .W       ($bits(sdw_pkg::sdw_pins_s)),
    .STAGES  (sdw_pkg::SYNC_STAGES),
    .RST_VAL (5'h19)                    // bus idle high, straps low, pin high
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sdw_pkg::sdw_state_s st;
  sdw_pkg::sdw_state_s next_st;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       byte_done;
  logic [6:0] my_addr;

  // bus events from the synchronised lines
  assign scl_rise  = pins.scl & ~st.scl_q;
  assign scl_fall  = ~pins.scl & st.scl_q;
  assign bus_start = pins.scl & st.scl_q & st.sda_q & ~pins.sda;
  assign bus_stop  = pins.scl & st.scl_q & ~st.sda_q & pins.sda;
  assign byte_done = scl_fall && (st.bit_cnt == sdw_pkg::BITS_BYTE);

  // [RL7] fixed high bits, strapped low bits
  // [RL8] strap levels pick one of four
  assign my_addr = sdw_pkg::slave_addr(pins.strap_hi, pins.strap_lo);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.scl_q    = pins.scl;
    next_st.sda_q    = pins.sda;
    next_st.code_stb = 1'b0;

    if (!st.ready) begin
      // let the strap synchronisers settle before sampling
      next_st.init_cnt = st.init_cnt + 2'h1;
      if (st.init_cnt == sdw_pkg::INIT_LAST) begin
        next_st.ready = 1'b1;
        // [RL9] power-up code from straps
        if (pins.strap_hi && pins.strap_lo) begin
          next_st.code = sdw_pkg::CODE_MID;
        end else begin
          next_st.code = sdw_pkg::CODE_ZERO;
        end
      end
    end else if (bus_start) begin
      // [RL2] start opens address phase
      next_st.phase   = sdw_pkg::SDW_ADDR;
      next_st.bit_cnt = 4'h0;
      next_st.drive   = 1'b0;
    end else if (bus_stop) begin
      // [RL12] stop returns to idle, bus released
      next_st.phase = sdw_pkg::SDW_IDLE;
      next_st.drive = 1'b0;
    end else begin
      unique case (st.phase)
        sdw_pkg::SDW_IDLE, sdw_pkg::SDW_SKIP: begin
          next_st.drive = 1'b0;
        end
        sdw_pkg::SDW_ADDR, sdw_pkg::SDW_CMD, sdw_pkg::SDW_DATA: begin
          if (scl_rise) begin
            next_st.shift   = {st.shift[6:0], pins.sda};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (byte_done) begin
            next_st.bit_cnt = 4'h0;
            if (st.phase == sdw_pkg::SDW_ADDR) begin
              // [RL3] ack own address with write bit
              if (st.shift[7:1] == my_addr && st.shift[0] == sdw_pkg::RW_WRITE) begin
                next_st.phase = sdw_pkg::SDW_ACK_ADDR;
                next_st.drive = 1'b1;
              end else begin
                // [RL13] foreign address or read, skip
                // [RL1] reads never answered
                next_st.phase = sdw_pkg::SDW_SKIP;
              end
            end else if (st.phase == sdw_pkg::SDW_CMD) begin
              // [RL3] ack command byte
              next_st.phase = sdw_pkg::SDW_ACK_CMD;
              next_st.drive = 1'b1;
            end else begin
              next_st.phase = sdw_pkg::SDW_ACK_DATA;
              next_st.drive = 1'b1;
            end
          end
        end
        sdw_pkg::SDW_ACK_ADDR: begin
          if (scl_fall) begin
            next_st.drive = 1'b0;
            next_st.phase = sdw_pkg::SDW_CMD;
          end
        end
        sdw_pkg::SDW_ACK_CMD: begin
          if (scl_fall) begin
            next_st.drive = 1'b0;
            next_st.phase = sdw_pkg::SDW_DATA;
            // [RL4] stage command bits on ack fall
            // [RL14] msbs from bits 1:0
            next_st.staged_msb = {st.shift[sdw_pkg::CMD_MSB_HI], st.shift[sdw_pkg::CMD_MSB_LO]};
            // [RL10] latest command shutdown bit
            next_st.cmd_pd = st.shift[sdw_pkg::CMD_PD_BIT];
          end
        end
        sdw_pkg::SDW_ACK_DATA: begin
          if (scl_fall) begin
            next_st.drive    = 1'b0;
            // [RL5] load code on final ack fall
            // [RL6] no stop needed for update
            next_st.code     = {st.staged_msb, st.shift};
            next_st.code_stb = 1'b1;
            // further bytes ignored until a new start
            next_st.phase    = sdw_pkg::SDW_SKIP;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '{ready:      1'b0,
              init_cnt:   2'h0,
              phase:      sdw_pkg::SDW_IDLE,
              bit_cnt:    4'h0,
              shift:      8'h00,
              scl_q:      1'b1,
              sda_q:      1'b1,
              drive:      1'b0,
              staged_msb: 2'h0,
              cmd_pd:     1'b0,
              code:       sdw_pkg::CODE_ZERO,
              code_stb:   1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // [RL1] sda only ever pulled low for acks
  assign sda_o        = 1'b0;
  assign sda_oe       = st.drive;
  // [RL11] code held through shutdown
  assign dac_code     = st.code;
  // [RL10] pin low or command bit forces shutdown
  assign dac_shutdown = st.cmd_pd | ~pins.pd_n;
  assign code_loaded  = st.code_stb;

endmodule : sdw_slave
`default_nettype wire

// ===== sdw_pkg.sv
// shared constants and types for the two-wire write-only dac code slave
`default_nettype none
package sdw_pkg;

  // ----------------------------------------------------------------
  // bus address
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FIXED_HI = 5'h0b;  // upper five address bits, 01011
  localparam logic       RW_WRITE      = 1'b0;   // read/write bit value for a write

  // ----------------------------------------------------------------
  // code register
  // ----------------------------------------------------------------
  localparam int         CODE_W    = 10;
  localparam logic [9:0] CODE_MID  = 10'h200;    // mid-scale power-up code
  localparam logic [9:0] CODE_ZERO = 10'h000;    // zero-scale power-up code

  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_PD_BIT  = 7;                // shutdown request
  localparam int CMD_MSB_HI  = 1;                // code bit 9
  localparam int CMD_MSB_LO  = 0;                // code bit 8

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         SYNC_STAGES = 2;        // flip-flops on each pin input
  localparam logic [1:0] INIT_LAST   = 2'h3;     // cycles after reset before straps are trusted
  localparam logic [3:0] BITS_BYTE   = 4'h8;

  // ----------------------------------------------------------------
  // transfer phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDW_IDLE,
    SDW_ADDR,
    SDW_ACK_ADDR,
    SDW_CMD,
    SDW_ACK_CMD,
    SDW_DATA,
    SDW_ACK_DATA,
    SDW_SKIP
  } sdw_phase_e;

  // synchronised pin levels
  typedef struct packed {
    logic scl;
    logic sda;
    logic strap_hi;
    logic strap_lo;
    logic pd_n;
  } sdw_pins_s;

  // whole state of the slave
  typedef struct packed {
    logic             ready;
    logic [1:0]       init_cnt;
    sdw_phase_e       phase;
    logic [3:0]       bit_cnt;
    logic [7:0]       shift;
    logic             scl_q;
    logic             sda_q;
    logic             drive;
    logic [1:0]       staged_msb;
    logic             cmd_pd;
    logic [9:0]       code;
    logic             code_stb;
  } sdw_state_s;

  // low two address bits from the strap levels
  function automatic logic [1:0] strap_addr(input logic hi, input logic lo);
    strap_addr = {hi ^ lo, ~hi};
  endfunction : strap_addr

  // full seven-bit slave address
  function automatic logic [6:0] slave_addr(input logic hi, input logic lo);
    slave_addr = {ADDR_FIXED_HI, strap_addr(hi, lo)};
  endfunction : slave_addr

endpackage : sdw_pkg
`default_nettype wire

// ===== sdw_sync.sv
// multi-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module sdw_sync #(
  parameter int         W       = 1,
  parameter int         STAGES  = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // pin side
  input  wire logic [W-1:0] async_in,
  // clocked side
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("sdw_sync needs at least two stages");
  end

  logic [STAGES-1:0][W-1:0] chain;

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      chain <= {STAGES{RST_VAL}};
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];

endmodule : sdw_sync
`default_nettype wire

// ===== sdw_slave_assertions.sv
// concurrent checks on the ports of the dac code slave
`timescale 1ns/1ps
`default_nettype none

module sdw_slave_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // two-wire bus
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  // strap and control pins
  input wire logic       addr_strap_hi,
  input wire logic       addr_strap_lo,
  input wire logic       power_down_pin_n,
  // dac side
  input wire logic [9:0] dac_code,
  input wire logic       dac_shutdown,
  input wire logic       code_loaded
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [3:0] age;

  // cycles since reset release, saturating
  always_ff @(posedge clk) begin
    if (srst) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  end

  sequence s_rel;
    $fell(srst);
  endsequence
  sequence s_ack_rise;
    $rose(sda_oe);
  endsequence

  // power-up code expected from the strap levels
  logic [9:0] pwrup_code;
  assign pwrup_code = (addr_strap_hi && addr_strap_lo) ? sdw_pkg::CODE_MID : sdw_pkg::CODE_ZERO;

  AST_SDA_CONST: assert property (!sda_o)
    else $error("sda driven high");
  AST_LOAD_PULSE: assert property (code_loaded |=> !code_loaded)
    else $error("load pulse longer than one cycle");
  AST_CODE_HOLD: assert property (age == 4'hf && $changed(dac_code) |-> code_loaded)
    else $error("code changed without a write");
  AST_ACK_RISE: assert property (s_ack_rise |-> !scl_i && !$past(scl_i, 2))
    else $error("ack raised outside clock low");
  AST_ACK_FALL: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("ack released while clock high");
  AST_ACK_LEN: assert property (s_ack_rise |-> sda_oe [*8] ##[1:30] !sda_oe)
    else $error("ack length wrong");
  AST_PD_PIN: assert property (!power_down_pin_n [*4] |-> dac_shutdown)
    else $error("pin low without shutdown");
  AST_PWRUP_CODE: assert property (s_rel |-> ##[3:5] dac_code == pwrup_code)
    else $error("power-up code wrong");
endmodule : sdw_slave_assertions

bind sdw_slave sdw_slave_assertions u_chk (.clk(clk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo),
  .power_down_pin_n(power_down_pin_n), .dac_code(dac_code), .dac_shutdown(dac_shutdown),
  .code_loaded(code_loaded));
`default_nettype wire

// ===== sdw_master_model.sv
// behavioural two-wire bus master issuing write byte transfers
`timescale 1ns/1ps
`default_nettype none

module sdw_master_model (
  // clock
  input  wire logic  clk,
  // bus lines
  input  wire logic  sda_in,
  output logic       scl,
  output logic       sda_low,
  // acks of the last transfer
  output logic [2:0] acks
);
  // idle bus released high
  // lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    acks = 3'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // one bit: set while clock low, sampled while high
  task automatic bit_x(input logic b, output logic s);
    sda_low <= !b;
    hold(5);
    scl <= 1'b1;
    hold(8);
    s = sda_in;
    scl <= 1'b0;
    hold(5);
  endtask : bit_x

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(v[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : send_byte

  task automatic write(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic stop);
    sda_low <= 1'b0;
    hold(5);
    scl <= 1'b1;
    hold(5);
    sda_low <= 1'b1;
    hold(5);
    scl <= 1'b0;
    hold(5);
    send_byte(a, acks[2]);
    send_byte(c, acks[1]);
    send_byte(d, acks[0]);
    if (stop) begin
      sda_low <= 1'b1;
      hold(5);
      scl <= 1'b1;
      hold(5);
      sda_low <= 1'b0;
    end
    hold(5);
  endtask : write
endmodule : sdw_master_model
`default_nettype wire

// ===== sdw_slave_tb_top.sv
// self-checking bench for the dac code slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("unexpected at %0t: mismatch", $time); end end

module sdw_slave_tb_top;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       hi = 1'b0;
  logic       lo = 1'b0;
  logic       pd_n = 1'b1;
  wire        scl;
  wire        sda_low;
  wire        sda_i;
  wire        sda_o;
  wire        sda_oe;
  wire  [9:0] dac_code;
  wire        dac_shutdown;
  wire        code_loaded;
  wire  [2:0] acks;
  int         fail_count = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         n_loads = 0;
  logic [6:0] addr_tab [4] = '{7'h2d, 7'h2f, 7'h2e, 7'h2c};

  // open-drain data line with pull-up
  assign sda_i = !(sda_low || (sda_oe && !sda_o));

  sdw_slave u_dut (.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_hi(hi), .addr_strap_lo(lo), .power_down_pin_n(pd_n), .dac_code(dac_code),
    .dac_shutdown(dac_shutdown), .code_loaded(code_loaded));
  sdw_master_model u_mst (.clk(clk), .sda_in(sda_i), .scl(scl), .sda_low(sda_low), .acks(acks));

  initial forever #2.5 clk = ~clk;

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // each strap setting: power-up code, foreign address, own address
  task automatic t_straps();
    logic [9:0] pu;
    for (int i = 0; i < 4; i++) begin
      hi <= i[1];
      lo <= i[0];
      srst <= 1'b1;
      hold(5);
      srst <= 1'b0;
      hold(10);
      pu = (i == 3) ? 10'h200 : 10'h000;
      `CHK(dac_code, pu)
      u_mst.write({addr_tab[(i + 1) % 4], 1'b0}, 8'h03, 8'h5a, 1'b1);
      `CHK(acks, 3'h0)
      `CHK(dac_code, pu)
      `CHK(n_loads, i)
      u_mst.write({addr_tab[i], 1'b0}, 8'h7c | i[1:0], 8'ha5 ^ i[7:0], 1'b1);
      `CHK(acks, 3'h7)
      `CHK(dac_code, {i[1:0], 8'ha5 ^ i[7:0]})
      `CHK(n_loads, i + 1)
      `CHK(dac_shutdown, 1'b0)
    end
  endtask : t_straps

  // shutdown by command bit and by pin, code kept
  task automatic t_power_down_pin_n();
    u_mst.write(8'h58, 8'h81, 8'h11, 1'b1);
    `CHK(dac_shutdown, 1'b1)
    `CHK(dac_code, 10'h111)
    pd_n <= 1'b0;
    hold(8);
    `CHK(dac_code, 10'h111)
    u_mst.write(8'h58, 8'h02, 8'h33, 1'b1);
    `CHK(dac_shutdown, 1'b1)
    pd_n <= 1'b1;
    hold(8);
    `CHK(dac_shutdown, 1'b0)
    `CHK(dac_code, 10'h233)
    `CHK(n_loads, 6)
  endtask : t_power_down_pin_n

  // no stop, repeated start, read bit refused
  task automatic t_nostop();
    u_mst.write(8'h58, 8'h01, 8'hc3, 1'b0);
    `CHK(dac_code, 10'h1c3)
    `CHK(n_loads, 7)
    u_mst.write(8'h58, 8'h03, 8'h0f, 1'b0);
    `CHK(dac_code, 10'h30f)
    u_mst.write(8'h59, 8'h00, 8'h00, 1'b1);
    `CHK(acks, 3'h0)
    `CHK(dac_code, 10'h30f)
    `CHK(n_loads, 8)
  endtask : t_nostop

  // count load pulses, read at the edge after launch
  always @(posedge clk) begin
    if (code_loaded === 1'b1) n_loads++;
  end

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    hold(5);
    srst <= 1'b0;
    hold(10);
    t_straps();
    t_power_down_pin_n();
    t_nostop();
    conclude();
  end
endmodule : sdw_slave_tb_top
`default_nettype wire
